/* File: tdmcm_defines.svh */
// constants for the tdm bus clock mode control block
`ifndef TDMCM_DEFINES_SVH
`define TDMCM_DEFINES_SVH
// bus geometry
`define TDMCM_STREAMS 32
`define TDMCM_SLOTS 128
`define TDMCM_MAX_STREAM 8'h1f
`define TDMCM_MAX_SLOT 8'h7f
`define TDMCM_SLOT_MAX_2M 8'h1f
`define TDMCM_SLOT_MAX_4M 8'h3f
`define TDMCM_LEGACY_TOP 4'hf
// stream rate codes
`define TDMCM_RATE_2M 2'h0
`define TDMCM_RATE_4M 2'h1
`define TDMCM_RATE_8M 2'h2
`define TDMCM_RATE_RST 8'haa
// clock modes
`define TDMCM_MODE_NONE 3'h0
`define TDMCM_MODE_SLAVE 3'h1
`define TDMCM_MODE_PRI_A 3'h2
`define TDMCM_MODE_PRI_B 3'h3
`define TDMCM_MODE_SEC_A 3'h4
`define TDMCM_MODE_SEC_B 3'h5
// slave submodes
`define TDMCM_SLV_A 3'h0
`define TDMCM_SLV_B 3'h1
`define TDMCM_SLV_LEG2 3'h2
`define TDMCM_SLV_LEG4 3'h3
`define TDMCM_SLV_LEG8 3'h4
`define TDMCM_SLV_LEG90 3'h5
`define TDMCM_SLV_FB_A 3'h6
`define TDMCM_SLV_FB_B 3'h7
// master submodes
`define TDMCM_MST_FREE 3'h0
`define TDMCM_MST_NETREF 3'h1
`define TDMCM_MST_NETREF2 3'h2
`define TDMCM_MST_SPAN 3'h3
`define TDMCM_MST_SPAN_FB 3'h4
// arguments
`define TDMCM_NETREF_8K 8'h00
`define TDMCM_NETREF_ON 3'h1
`define TDMCM_LEG_MAX 3'h5
`define TDMCM_LEG_NONE 3'h0
`define TDMCM_CHAR_E 8'h45
`define TDMCM_CHAR_D 8'h44
// clock monitor indices
`define TDMCM_MON_A 0
`define TDMCM_MON_B 1
`define TDMCM_MON_LEG 2
`define TDMCM_MON_L90 3
// clock error bits
`define TDMCM_ERR_A 0
`define TDMCM_ERR_B 1
`define TDMCM_ERR_LEG 2
`define TDMCM_ERR_L90 3
`define TDMCM_ERR_PLL 4
`define TDMCM_ERR_COMPAT 5
`define TDMCM_ERR_FAILSAFE 6
`define TDMCM_ERR_RST 7'h20
`define TDMCM_STAT_REF_BIT 7
// timing
`define TDMCM_CLK_NS 8
`define TDMCM_LOSS_NS 250
`define TDMCM_LOSS_CYC ((`TDMCM_LOSS_NS + `TDMCM_CLK_NS - 1) / `TDMCM_CLK_NS)
`endif

/* File: tdmcm_pkg.sv */
// types for the tdm bus clock mode control block
package tdmcm_pkg;
   // set clock command arguments
   typedef struct packed {
      logic [2:0] mode;
      logic [2:0] submode;
      logic [2:0] arg_a;
      logic [7:0] arg_bb;
      logic [7:0] arg_c;
   } tdmcm_clk_cfg_t;
   // termination command letters
   typedef struct packed {
      logic [7:0] bus_char;
      logic [7:0] legacy_char;
   } tdmcm_term_t;
   // clocking state, one-hot
   typedef enum logic [5:0] {
      TDMCM_LOCAL = 6'h01,
      TDMCM_SLAVE = 6'h02,
      TDMCM_SLAVE_FB = 6'h04,
      TDMCM_PRIMARY = 6'h08,
      TDMCM_SECONDARY = 6'h10,
      TDMCM_TAKEOVER = 6'h20
   } tdmcm_state_t;
   // selected clock source
   typedef enum logic [3:0] {
      TDMCM_SRC_LOCAL = 4'h0,
      TDMCM_SRC_CT_A = 4'h1,
      TDMCM_SRC_CT_B = 4'h2,
      TDMCM_SRC_LEGACY = 4'h3,
      TDMCM_SRC_LEG90 = 4'h4,
      TDMCM_SRC_NETREF = 4'h5,
      TDMCM_SRC_NETREF2 = 4'h6,
      TDMCM_SRC_SPAN = 4'h7,
      TDMCM_SRC_HOLDOVER = 4'h8
   } tdmcm_src_t;
endpackage : tdmcm_pkg

/* File: tdmcm_clock_ctrl.sv */
// tdm bus clock mode, stream rate, termination and clock error control
`timescale 1ns/1ns
`include "tdmcm_defines.svh"

module tdmcm_clock_ctrl #(
   parameter int LOSS_CYC = `TDMCM_LOSS_CYC
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // set clock command
   input wire logic set_clock_cmd,
   input wire tdmcm_pkg::tdmcm_clk_cfg_t clk_cfg,
   // stream rate command
   input wire logic stream_rate_cmd,
   input wire logic [7:0] rate_codes,
   // termination command
   input wire logic termination_cmd,
   input wire tdmcm_pkg::tdmcm_term_t term_chars,
   output logic cmd_reject,
   // address checks
   input wire logic [15:0] slot_addr,
   input wire logic [3:0] legacy_stream,
   output logic slot_addr_ok_reg,
   output logic legacy_output_stream_reg,
   output logic [2:0] legacy_index_reg,
   // bus clocks from the backplane
   input wire logic ct_clk_a,
   input wire logic ct_clk_b,
   input wire logic legacy_clk,
   input wire logic legacy90_clk,
   input wire logic span_ref_ok,
   // clocking outputs
   output logic drive_clk_a_reg,
   output logic drive_clk_b_reg,
   output tdmcm_pkg::tdmcm_src_t clk_src_reg,
   output logic netref_out_en_reg,
   output logic [3:0] netref_span_reg,
   output logic [2:0] legacy_clk_sel_reg,
   // configuration status
   output tdmcm_pkg::tdmcm_clk_cfg_t cfg_reg,
   output logic [7:0] rate_reg,
   output logic bus_term_en_reg,
   output logic legacy_term_en_reg,
   output logic [7:0] ref_status_reg,
   // clock error report
   output logic [6:0] clk_err_reg,
   output logic clock_error_report
);
   import tdmcm_pkg::*;

   // counter too narrow or zero window cannot detect loss; refused at elaboration
   if (LOSS_CYC < 1 || LOSS_CYC > 255) begin : g_bad_loss
      $error("LOSS_CYC out of range");
   end

   // max slot for a rate code
   function automatic logic [7:0] slot_max(input logic [1:0] rate);
      slot_max = (rate == `TDMCM_RATE_2M) ? `TDMCM_SLOT_MAX_2M :
                 (rate == `TDMCM_RATE_4M) ? `TDMCM_SLOT_MAX_4M : `TDMCM_MAX_SLOT;
   endfunction : slot_max

   // master source for a submode
   function automatic tdmcm_src_t master_src(input logic [2:0] sub, input logic span_ok);
      case (sub)
         `TDMCM_MST_NETREF: master_src = TDMCM_SRC_NETREF;
         `TDMCM_MST_NETREF2: master_src = TDMCM_SRC_NETREF2;
         `TDMCM_MST_SPAN: master_src = TDMCM_SRC_SPAN;
         `TDMCM_MST_SPAN_FB: master_src = span_ok ? TDMCM_SRC_SPAN : TDMCM_SRC_NETREF;
         default: master_src = TDMCM_SRC_LOCAL;
      endcase
   endfunction : master_src

   // state and shadow registers
   tdmcm_state_t state_reg; // clocking state
   tdmcm_state_t state_next;
   logic [6:0] err_next; // error mask next value
   logic [6:0] err_sent_reg; // last reported mask
   logic failsafe_reg; // fallback or takeover happened
   logic [3:0] sync1_reg; // first sync stage, read only by stage two
   logic [3:0] sync2_reg; // second sync stage
   logic [3:0] sync3_reg; // edge history
   logic span_s1_reg;
   logic span_ok_reg;
   logic [7:0] loss_cnt_reg [4]; // cycles since last rising edge

   // command checks
   wire is_slave = clk_cfg.mode == `TDMCM_MODE_SLAVE;
   wire is_master = clk_cfg.mode >= `TDMCM_MODE_PRI_A && clk_cfg.mode <= `TDMCM_MODE_SEC_B;
   wire netref_sub = clk_cfg.submode == `TDMCM_MST_NETREF || clk_cfg.submode == `TDMCM_MST_NETREF2;
   wire slave_ok = clk_cfg.arg_a <= `TDMCM_NETREF_ON;
   wire master_ok = clk_cfg.submode <= `TDMCM_MST_SPAN_FB && clk_cfg.arg_a <= `TDMCM_LEG_MAX
                    && (!netref_sub || clk_cfg.arg_bb == `TDMCM_NETREF_8K);
   wire mode_ok = clk_cfg.mode <= `TDMCM_MODE_SEC_B
                  && (!is_slave || slave_ok) && (!is_master || master_ok);
   wire mode_take = set_clock_cmd && mode_ok;
   wire rate_ok = rate_codes[1:0] <= `TDMCM_RATE_8M && rate_codes[3:2] <= `TDMCM_RATE_8M
                  && rate_codes[5:4] <= `TDMCM_RATE_8M && rate_codes[7:6] <= `TDMCM_RATE_8M;
   wire bus_e = term_chars.bus_char == `TDMCM_CHAR_E;
   wire leg_e = term_chars.legacy_char == `TDMCM_CHAR_E;
   wire term_ok = (bus_e || term_chars.bus_char == `TDMCM_CHAR_D)
                  && (leg_e || term_chars.legacy_char == `TDMCM_CHAR_D);
   assign cmd_reject = (set_clock_cmd && !mode_ok) || (stream_rate_cmd && !rate_ok)
                       || (termination_cmd && !term_ok);

   // slot address decode against group rate
   wire [7:0] q_stream = slot_addr[15:8];
   wire [7:0] q_slot = slot_addr[7:0];
   wire [1:0] q_rate = rate_reg[{q_stream[3:2], 1'b0} +: 2];
   wire q_legacy = q_stream <= {4'h0, `TDMCM_LEGACY_TOP};
   wire slot_ok_next = q_stream <= `TDMCM_MAX_STREAM
                       && q_slot <= (q_legacy ? slot_max(q_rate) : `TDMCM_MAX_SLOT);

   // clock monitor view
   wire [3:0] clk_rise = sync2_reg & ~sync3_reg;
   wire [3:0] clk_lost;
   for (genvar i = 0; i < 4; i++) begin : g_lost
      assign clk_lost[i] = loss_cnt_reg[i] == 8'(LOSS_CYC);
   end
   wire cfg_b = cfg_reg.mode == `TDMCM_MODE_PRI_B || cfg_reg.mode == `TDMCM_MODE_SEC_B;
   wire fb_sub = cfg_reg.submode == `TDMCM_SLV_FB_A || cfg_reg.submode == `TDMCM_SLV_FB_B;
   wire slv_on_b = cfg_reg.submode == `TDMCM_SLV_B || cfg_reg.submode == `TDMCM_SLV_FB_B;
   wire sec_lost = cfg_b ? clk_lost[`TDMCM_MON_A] : clk_lost[`TDMCM_MON_B];
   wire slv_lost = slv_on_b ? clk_lost[`TDMCM_MON_B] : clk_lost[`TDMCM_MON_A];

   // state sequencing; an accepted set clock command always overrides automatic moves
   always_comb begin
      state_next = state_reg;
      if (mode_take) begin
         case (clk_cfg.mode)
            `TDMCM_MODE_NONE: state_next = TDMCM_LOCAL;
            `TDMCM_MODE_SLAVE: state_next = TDMCM_SLAVE;
            `TDMCM_MODE_PRI_A, `TDMCM_MODE_PRI_B: state_next = TDMCM_PRIMARY;
            default: state_next = TDMCM_SECONDARY;
         endcase
      end else if (state_reg == TDMCM_SLAVE && fb_sub && slv_lost) begin
         state_next = TDMCM_SLAVE_FB;
      end else if (state_reg == TDMCM_SECONDARY && sec_lost) begin
         state_next = TDMCM_TAKEOVER;
      end
   end

   // source, drive and status selection
   tdmcm_src_t src_next;
   logic drive_on;
   always_comb begin
      src_next = TDMCM_SRC_LOCAL;
      drive_on = 1'b0;
      unique case (state_reg)
         TDMCM_LOCAL: src_next = TDMCM_SRC_LOCAL;
         TDMCM_SLAVE: begin
            case (cfg_reg.submode)
               `TDMCM_SLV_LEG2, `TDMCM_SLV_LEG4, `TDMCM_SLV_LEG8: src_next = TDMCM_SRC_LEGACY;
               `TDMCM_SLV_LEG90: src_next = TDMCM_SRC_LEG90;
               default: src_next = slv_on_b ? TDMCM_SRC_CT_B : TDMCM_SRC_CT_A;
            endcase
         end
         TDMCM_SLAVE_FB: src_next = slv_on_b ? TDMCM_SRC_CT_A : TDMCM_SRC_CT_B;
         TDMCM_PRIMARY: begin
            src_next = master_src(cfg_reg.submode, span_ok_reg);
            drive_on = 1'b1;
         end
         TDMCM_SECONDARY: begin
            src_next = cfg_b ? TDMCM_SRC_CT_A : TDMCM_SRC_CT_B;
            drive_on = 1'b1;
         end
         TDMCM_TAKEOVER: begin
            src_next = (cfg_reg.submode == `TDMCM_MST_FREE) ? TDMCM_SRC_HOLDOVER
                       : master_src(cfg_reg.submode, span_ok_reg);
            drive_on = 1'b1;
         end
         default: src_next = TDMCM_SRC_LOCAL;
      endcase
   end
   wire netref_next = (state_reg == TDMCM_SLAVE || state_reg == TDMCM_SLAVE_FB)
                      && cfg_reg.arg_a == `TDMCM_NETREF_ON;
   wire [2:0] leg_sel_next = drive_on ? cfg_reg.arg_a : `TDMCM_LEG_NONE;
   wire span_ref = src_next == TDMCM_SRC_SPAN;
   wire [7:0] status_next = {span_ref, 3'h0, span_ref ? cfg_reg.arg_bb[3:0] : 4'h0};

   // error mask; bit 5 stuck at one for compatibility
   always_comb begin
      err_next = `TDMCM_ERR_RST;
      err_next[`TDMCM_ERR_A] = clk_lost[`TDMCM_MON_A] && src_next == TDMCM_SRC_CT_A;
      err_next[`TDMCM_ERR_B] = clk_lost[`TDMCM_MON_B] && src_next == TDMCM_SRC_CT_B;
      err_next[`TDMCM_ERR_LEG] = clk_lost[`TDMCM_MON_LEG] && src_next == TDMCM_SRC_LEGACY;
      err_next[`TDMCM_ERR_L90] = clk_lost[`TDMCM_MON_L90] && src_next == TDMCM_SRC_LEG90;
      err_next[`TDMCM_ERR_PLL] = drive_on && cfg_reg.submode == `TDMCM_MST_SPAN_FB && !span_ok_reg;
      err_next[`TDMCM_ERR_FAILSAFE] = failsafe_reg;
   end

   // link clock sampling; stage one feeds stage two only
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_reg <= 4'h0;
         sync2_reg <= 4'h0;
         sync3_reg <= 4'h0;
         span_s1_reg <= 1'b0;
         span_ok_reg <= 1'b0;
      end else begin
         sync1_reg <= {legacy90_clk, legacy_clk, ct_clk_b, ct_clk_a};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         span_s1_reg <= span_ref_ok;
         span_ok_reg <= span_s1_reg;
      end
   end

   // missing-edge watchdogs, saturating
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < 4; i++) loss_cnt_reg[i] <= 8'h00;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (clk_rise[i]) loss_cnt_reg[i] <= 8'h00;
            else if (!clk_lost[i]) loss_cnt_reg[i] <= loss_cnt_reg[i] + 8'h01;
         end
      end
   end

   // configuration registers
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= TDMCM_LOCAL;
         cfg_reg <= '0;
         rate_reg <= `TDMCM_RATE_RST;
         bus_term_en_reg <= 1'b0;
         legacy_term_en_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (mode_take) cfg_reg <= clk_cfg;
         if (stream_rate_cmd && rate_ok) rate_reg <= rate_codes;
         if (termination_cmd && term_ok) begin
            bus_term_en_reg <= bus_e;
            legacy_term_en_reg <= leg_e;
         end
      end
   end

   // failsafe: automatic move sets, new mode command clears, set wins
   wire auto_move = state_next != state_reg && !mode_take;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) failsafe_reg <= 1'b0;
      else if (auto_move) failsafe_reg <= 1'b1;
      else if (mode_take) failsafe_reg <= 1'b0;
   end

   // output registers
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         clk_src_reg <= TDMCM_SRC_LOCAL;
         drive_clk_a_reg <= 1'b0;
         drive_clk_b_reg <= 1'b0;
         netref_out_en_reg <= 1'b0;
         netref_span_reg <= 4'h0;
         legacy_clk_sel_reg <= `TDMCM_LEG_NONE;
         ref_status_reg <= 8'h00;
         clk_err_reg <= `TDMCM_ERR_RST;
         slot_addr_ok_reg <= 1'b0;
         legacy_output_stream_reg <= 1'b0;
         legacy_index_reg <= 3'h0;
      end else begin
         clk_src_reg <= src_next;
         drive_clk_a_reg <= drive_on && !cfg_b;
         drive_clk_b_reg <= drive_on && cfg_b;
         netref_out_en_reg <= netref_next;
         netref_span_reg <= cfg_reg.arg_bb[3:0];
         legacy_clk_sel_reg <= leg_sel_next;
         ref_status_reg <= status_next;
         clk_err_reg <= err_next;
         slot_addr_ok_reg <= slot_ok_next;
         legacy_output_stream_reg <= !legacy_stream[0];
         legacy_index_reg <= legacy_stream[3:1];
      end
   end

   // change report; compares against the last mask sent
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) err_sent_reg <= `TDMCM_ERR_RST;
      else err_sent_reg <= clk_err_reg;
   end
   assign clock_error_report = clk_err_reg != err_sent_reg;

   // checks
   sequence s_fb_cause;
      state_reg == TDMCM_SLAVE && fb_sub && slv_lost && !set_clock_cmd;
   endsequence
   sequence s_fb_effect;
      state_reg == TDMCM_SLAVE_FB ##1 failsafe_reg ##1 clk_err_reg[`TDMCM_ERR_FAILSAFE];
   endsequence
   a_slave_fallback: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_fb_cause |=> s_fb_effect) else $error("fallback not taken");
   sequence s_sec_cause;
      state_reg == TDMCM_SECONDARY && sec_lost && !set_clock_cmd;
   endsequence
   a_secondary_takeover: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_sec_cause |=> state_reg == TDMCM_TAKEOVER ##1 (drive_clk_a_reg != drive_clk_b_reg))
      else $error("no takeover");
   a_holdover_src: assert property (@(posedge ref_clk) disable iff (!rst_b)
      state_reg == TDMCM_TAKEOVER && cfg_reg.submode == `TDMCM_MST_FREE
      |=> clk_src_reg == TDMCM_SRC_HOLDOVER) else $error("holdover not used");
   a_bad_mode_kept: assert property (@(posedge ref_clk) disable iff (!rst_b)
      set_clock_cmd && clk_cfg.mode > `TDMCM_MODE_SEC_B |=> $stable(cfg_reg))
      else $error("bad mode taken");
   a_netref_rate: assert property (@(posedge ref_clk) disable iff (!rst_b)
      set_clock_cmd && is_master && netref_sub && clk_cfg.arg_bb != `TDMCM_NETREF_8K
      |-> cmd_reject) else $error("netref rate not refused");
   a_netref_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
      netref_out_en_reg |-> $past(cfg_reg.arg_a) == `TDMCM_NETREF_ON) else $error("netref ungated");
   a_compat_bit: assert property (@(posedge ref_clk) disable iff (!rst_b)
      clk_err_reg[`TDMCM_ERR_COMPAT]) else $error("compat bit clear");
   a_err_report: assert property (@(posedge ref_clk) disable iff (!rst_b)
      clock_error_report == (clk_err_reg != $past(clk_err_reg)))
      else $error("change not reported");
   a_slot_limit: assert property (@(posedge ref_clk) disable iff (!rst_b)
      q_legacy && q_rate == `TDMCM_RATE_2M && q_slot > `TDMCM_SLOT_MAX_2M
      |=> !slot_addr_ok_reg) else $error("slot over limit accepted");
   a_term_apply: assert property (@(posedge ref_clk) disable iff (!rst_b)
      termination_cmd && term_ok |=> bus_term_en_reg == $past(bus_e)
      && legacy_term_en_reg == $past(leg_e)) else $error("termination not applied");
   a_legacy_map: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $past(rst_b) |-> legacy_output_stream_reg == !$past(legacy_stream[0])
      && legacy_index_reg == $past(legacy_stream[3:1])) else $error("legacy map wrong");
endmodule : tdmcm_clock_ctrl

/* File: tdmcm_bus_model.sv */
// far-side board model that sources the shared backplane clocks
`timescale 1ns/1ns
module tdmcm_bus_model #(
   parameter int HALF_NS = 40
) (
   // clock enables, low stops that clock
   input wire logic run_a,
   input wire logic run_b,
   input wire logic run_leg,
   // backplane clocks
   output logic ct_clk_a,
   output logic ct_clk_b,
   output logic legacy_clk,
   output logic legacy90_clk
);
   // a single master board sources every bus clock, the rest only listen
   initial begin
      // legacy-90 copy has its own process, so it is not touched here
      {ct_clk_a, ct_clk_b, legacy_clk} = 3'h0;
      // odd offset keeps the bus clocks unrelated to the bench clock
      #3;
      forever begin
         #(HALF_NS);
         // a failed driver parks its line low rather than toggling
         ct_clk_a = run_a & ~ct_clk_a;
         ct_clk_b = run_b & ~ct_clk_b;
         legacy_clk = run_leg & ~legacy_clk;
      end
   end
   // quarter-period shifted copy for the legacy-90 clock
   always @(legacy_clk) legacy90_clk <= #(HALF_NS / 2) legacy_clk;
endmodule : tdmcm_bus_model

/* File: tb_top.sv */
// self-checking bench for the tdm bus clock mode control block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
   $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_top;
   import tdmcm_pkg::*;
   // stimulus and observed signals
   logic ref_clk, rst_b, set_clock_cmd, stream_rate_cmd, termination_cmd;
   tdmcm_clk_cfg_t clk_cfg, cfg_reg, cur;
   tdmcm_term_t term_chars;
   tdmcm_src_t clk_src_reg;
   logic [7:0] rate_codes, rate_reg, ref_status_reg;
   logic [15:0] slot_addr;
   logic [3:0] legacy_stream, netref_span_reg, lsn;
   logic [2:0] legacy_index_reg, legacy_clk_sel_reg;
   logic [6:0] clk_err_reg;
   logic cmd_reject, slot_addr_ok_reg, legacy_output_stream_reg, span_ref_ok;
   logic ct_clk_a, ct_clk_b, legacy_clk, legacy90_clk, run_a, run_b, run_leg;
   logic drive_clk_a_reg, drive_clk_b_reg, netref_out_en_reg;
   logic bus_term_en_reg, legacy_term_en_reg, clock_error_report;
   // scoreboard state
   int num_errors = 0;
   int n_compared = 0;
   int m_rate, st, sl, lim;
   bit seen;
   // short loss count keeps the fallback runs brief
   tdmcm_clock_ctrl #(.LOSS_CYC(12)) u_tdmcm_clock_ctrl (
      .ref_clk, .rst_b, .set_clock_cmd, .clk_cfg, .stream_rate_cmd, .rate_codes,
      .termination_cmd, .term_chars, .cmd_reject, .slot_addr, .legacy_stream,
      .slot_addr_ok_reg, .legacy_output_stream_reg, .legacy_index_reg, .ct_clk_a,
      .ct_clk_b, .legacy_clk, .legacy90_clk, .span_ref_ok, .drive_clk_a_reg,
      .drive_clk_b_reg, .clk_src_reg, .netref_out_en_reg, .netref_span_reg,
      .legacy_clk_sel_reg, .cfg_reg, .rate_reg, .bus_term_en_reg, .legacy_term_en_reg,
      .ref_status_reg, .clk_err_reg, .clock_error_report);
   tdmcm_bus_model u_tdmcm_bus_model (.run_a, .run_b, .run_leg, .ct_clk_a,
      .ct_clk_b, .legacy_clk, .legacy90_clk);
   // 125 MHz bench clock
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // hang guard, over twenty times the expected run
   initial begin
      #100000;
      num_errors++;
      test_done;
   end
   task automatic test_done;
      if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done
   // expected clock source for a configuration with healthy clocks
   function automatic tdmcm_src_t exp_src(input tdmcm_clk_cfg_t c);
      if (c.mode == 3'h1) begin
         case (c.submode)
            3'h0, 3'h6: return TDMCM_SRC_CT_A;
            3'h1, 3'h7: return TDMCM_SRC_CT_B;
            3'h5: return TDMCM_SRC_LEG90;
            default: return TDMCM_SRC_LEGACY;
         endcase
      end
      // secondary locks to the opposite clock
      if (c.mode == 3'h4) return TDMCM_SRC_CT_B;
      if (c.mode == 3'h5) return TDMCM_SRC_CT_A;
      if (c.mode == 3'h0) return TDMCM_SRC_LOCAL;
      case (c.submode)
         3'h0: return TDMCM_SRC_LOCAL;
         3'h1: return TDMCM_SRC_NETREF;
         3'h2: return TDMCM_SRC_NETREF2;
         default: return TDMCM_SRC_SPAN;
      endcase
   endfunction : exp_src
   // one strobe with its data, reject sampled while the strobe stands
   task automatic cmd(input int w, input logic [26:0] d, input logic rej);
      @(posedge ref_clk);
      case (w)
         0: begin
            clk_cfg <= d;
            set_clock_cmd <= 1'b1;
         end
         1: begin
            rate_codes <= d[7:0];
            stream_rate_cmd <= 1'b1;
         end
         default: begin
            term_chars <= d[15:0];
            termination_cmd <= 1'b1;
         end
      endcase
      #1;
      `CHK("reject", rej, cmd_reject)
      @(posedge ref_clk);
      {set_clock_cmd, stream_rate_cmd, termination_cmd} <= 3'h0;
      repeat (3) @(posedge ref_clk);
      #1;
      if (!rej && w == 0) cur = d;
   endtask : cmd
   // compare every clocking output with the model
   task automatic check_clk;
      tdmcm_src_t s;
      s = exp_src(cur);
      `CHK("cfg", cur, cfg_reg)
      `CHK("src", s, clk_src_reg)
      `CHK("drv_a", (cur.mode == 2 || cur.mode == 4), drive_clk_a_reg)
      `CHK("drv_b", (cur.mode == 3 || cur.mode == 5), drive_clk_b_reg)
      `CHK("leg_sel", ((cur.mode > 1) ? cur.arg_a : 3'h0), legacy_clk_sel_reg)
      `CHK("nr_en", (cur.mode == 1 && cur.arg_a == 1), netref_out_en_reg)
      `CHK("nr_span", cur.arg_bb[3:0], netref_span_reg)
      `CHK("stat", (s == TDMCM_SRC_SPAN ? {4'h8, cur.arg_bb[3:0]} : 8'h00), ref_status_reg)
   endtask : check_clk
   task automatic sc(input logic [2:0] m, s, a, input logic [7:0] bb, input logic rej);
      cmd(0, {m, s, a, bb, 8'h00}, rej);
      check_clk;
   endtask : sc
   // wait for an error bit, noting a report at or just after its change
   task automatic wait_err(input int b);
      seen = 0;
      for (int i = 0; i < 100; i++) begin
         @(posedge ref_clk);
         #1;
         if (clk_err_reg[b] === 1'b1) begin
            seen = (clock_error_report === 1'b1);
            @(posedge ref_clk);
            #1;
            seen = seen || (clock_error_report === 1'b1);
            break;
         end
      end
   endtask : wait_err
   // main sequence
   initial begin
      void'($urandom(16999));
      rst_b = 1'b0;
      {set_clock_cmd, stream_rate_cmd, termination_cmd} = 3'h0;
      clk_cfg = '0;
      rate_codes = 8'h00;
      term_chars = '0;
      slot_addr = 16'h0000;
      legacy_stream = 4'h0;
      span_ref_ok = 1'b1;
      run_a = 1'b1;
      run_b = 1'b1;
      run_leg = 1'b1;
      cur = '0;
      m_rate = 'haa;
      repeat (20) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      #1;
      `CHK("rate", m_rate[7:0], rate_reg)
      `CHK("term", 2'h0, {legacy_term_en_reg, bus_term_en_reg})
      `CHK("err", 7'h20, clk_err_reg)
      check_clk;
      // every letter pair, then a bad letter that must change nothing
      for (int i = 0; i < 4; i++) begin
         cmd(2, {11'h0, (i[0] ? 8'h45 : 8'h44), (i[1] ? 8'h45 : 8'h44)}, 1'b0);
         `CHK("term", i[1:0], {legacy_term_en_reg, bus_term_en_reg})
      end
      cmd(2, {11'h0, 8'h58, 8'h45}, 1'b1);
      `CHK("term", 2'h3, {legacy_term_en_reg, bus_term_en_reg})
      // each rate code everywhere, then random mixes, with address queries after every rate
      for (int k = 0; k < 6; k++) begin
         m_rate = 0;
         for (int g = 0; g < 4; g++) m_rate |= ((k < 3) ? k : $urandom % 3) << (2 * g);
         cmd(1, 27'(m_rate), 1'b0);
         `CHK("rate", m_rate[7:0], rate_reg)
         for (int j = 0; j < 8; j++) begin
            @(posedge ref_clk);
            st = $urandom % 40;
            sl = $urandom % 256;
            lsn = 4'(k * 8 + j);
            slot_addr <= {st[7:0], sl[7:0]};
            legacy_stream <= lsn;
            lim = (st > 31) ? -1 : 127;
            if (st < 16 && m_rate[2 * (st / 4) +: 2] != 2) lim = m_rate[2 * (st / 4)] ? 63 : 31;
            @(posedge ref_clk);
            #1;
            `CHK("slot_ok", (sl <= lim), slot_addr_ok_reg)
            `CHK("leg_out", ~lsn[0], legacy_output_stream_reg)
            `CHK("leg_idx", lsn[3:1], legacy_index_reg)
         end
      end
      cmd(1, 27'h0ff, 1'b1);
      `CHK("rate", m_rate[7:0], rate_reg)
      // every mode, submode and legacy clock choice, plus refusals
      for (int m = 0; m < 8; m++) sc(m[2:0], 3'h0, 3'h0, 8'h00, m > 5);
      for (int s = 0; s < 8; s++) sc(3'h1, s[2:0], {2'h0, s[0]}, 8'($urandom), 1'b0);
      sc(3'h1, 3'h0, 3'h2, 8'h00, 1'b1);
      for (int s = 0; s < 5; s++) sc(3'h2, s[2:0], s[2:0], (s == 1 || s == 2) ? 8'h00 : 8'h05, 1'b0);
      sc(3'h3, 3'h1, 3'h0, 8'h01, 1'b1);
      sc(3'h3, 3'h5, 3'h0, 8'h00, 1'b1);
      sc(3'h3, 3'h0, 3'h6, 8'h00, 1'b1);
      sc(3'h3, 3'h0, 3'h5, 8'h00, 1'b0);
      // span reference lost under span-with-fallback
      sc(3'h2, 3'h4, 3'h0, 8'h03, 1'b0);
      @(posedge ref_clk);
      span_ref_ok <= 1'b0;
      wait_err(4);
      `CHK("report", 1'b1, seen)
      `CHK("pll_err", 1'b1, clk_err_reg[4])
      `CHK("src", TDMCM_SRC_NETREF, clk_src_reg)
      @(posedge ref_clk);
      span_ref_ok <= 1'b1;
      repeat (10) @(posedge ref_clk);
      // legacy clock lost while slaved to it: error bit only, no fallback
      sc(3'h1, 3'h2, 3'h0, 8'h00, 1'b0);
      @(posedge ref_clk);
      run_leg <= 1'b0;
      wait_err(2);
      `CHK("report", 1'b1, seen)
      `CHK("src", TDMCM_SRC_LEGACY, clk_src_reg)
      @(posedge ref_clk);
      run_leg <= 1'b1;
      repeat (20) @(posedge ref_clk);
      // slave auto-fallback from clock a to clock b, then reissue
      sc(3'h1, 3'h6, 3'h0, 8'h00, 1'b0);
      @(posedge ref_clk);
      run_a <= 1'b0;
      wait_err(6);
      `CHK("report", 1'b1, seen)
      `CHK("src", TDMCM_SRC_CT_B, clk_src_reg)
      @(posedge ref_clk);
      run_a <= 1'b1;
      sc(3'h1, 3'h0, 3'h0, 8'h00, 1'b0);
      `CHK("failsafe", 1'b0, clk_err_reg[6])
      // secondary takes over on loss of the primary clock, then reissue
      sc(3'h4, 3'h0, 3'h0, 8'h00, 1'b0);
      @(posedge ref_clk);
      run_b <= 1'b0;
      wait_err(6);
      `CHK("report", 1'b1, seen)
      `CHK("src", TDMCM_SRC_HOLDOVER, clk_src_reg)
      `CHK("drv_a", 1'b1, drive_clk_a_reg)
      @(posedge ref_clk);
      run_b <= 1'b1;
      // primary must be running again before the secondary is reissued
      repeat (20) @(posedge ref_clk);
      sc(3'h4, 3'h0, 3'h0, 8'h00, 1'b0);
      test_done;
   end
endmodule : tb_top
